// ==== src/isa_pnp_pkg.sv ====
package isa_pnp_pkg;
    // Number of default words read from the EEPROM after reset
    localparam int NUM_WORDS = 14;
    // Word indices of the default image
    localparam logic [3:0] MEM_BASE_WORD0 = 4'h0;
    localparam logic [3:0] MEM_UPPER_WORD0 = 4'h2;
    localparam logic [3:0] IO_BASE_WORD0 = 4'h4;
    localparam logic [3:0] SIZE_WORD = 4'h9;
    localparam logic [3:0] IRQ_WORD = 4'ha;
    localparam logic [3:0] DMA_CHAN_WORD = 4'hb;
    localparam logic [3:0] CTRL_WORD = 4'hc;
    localparam logic [3:0] DMA_MAP_WORD = 4'hd;
    // Field positions: top bit of device 0, step between devices
    localparam int SIZE_TOP = 15;
    localparam int SIZE_STEP = 3;
    localparam int IRQ_TOP = 15;
    localparam int IRQ_STEP = 4;
    localparam int DMA_CHAN_TOP = 11;
    localparam int DMA_CHAN_STEP = 3;
    localparam int ACTIVE_TOP = 15;
    localparam int XCVR_ENABLE_0_LSB = 8;
    localparam int MODE_BIT = 4;
    localparam int DMA_MAP_STEP = 3;
    // Transceiver enable codes in mode 0
    localparam logic [2:0] OEN_LD0 = 3'h0;
    localparam logic [2:0] OEN_LD1 = 3'h1;
    localparam logic [2:0] OEN_EITHER = 3'h2;
    // ISA interrupt levels of the eleven outputs, lowest index first
    localparam logic [43:0] IRQ_LEVEL_LIST = 44'hfecba976543;
    // Reset values
    localparam logic [7:0] CSN_RESET = 8'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    // EEPROM read: start bit plus read opcode, then 8 address bits
    localparam logic [2:0] READ_OPCODE = 3'h6;
    localparam logic [4:0] CMD_BITS = 5'h0b;
    // A read returns a dummy zero ahead of the 16 data bits
    localparam logic [4:0] READ_BITS = 5'h11;
    // Cycles between winning the EEPROM and driving it
    localparam logic [4:0] SETTLE_CYCLES = 5'h02;
    // Card plug-and-play state
    typedef enum logic {PNP_LOADING, PNP_WAIT_KEY} pnp_state_t;
    // EEPROM sequencer state
    typedef enum logic [2:0] {EE_CLAIM, EE_SETTLE, EE_CMD, EE_READ, EE_GAP, EE_DONE} ee_state_t;
endpackage : isa_pnp_pkg

// ==== src/io_match.sv ====
`timescale 1ns/1ps
// Compares an I/O address with a base, ignoring bits below the block size
module io_match (
    input wire logic [15:0] addr,
    input wire logic [15:0] base,
    input wire logic [2:0] sizeCode,
    output logic hit
);
    // Mask of decoded bits; codes above 64 bytes are held at 64 bytes
    logic [15:0] mask;

    // Mask build and compare
    always_comb begin
        mask = 16'hffff << ((sizeCode == 3'h7) ? 3'h6 : sizeCode);
        hit = ((addr ^ base) & mask) == 16'h0000;
    end
endmodule : io_match

// ==== src/ee_loader.sv ====
`timescale 1ns/1ps
// Reads the default words from the serial EEPROM after reset
module ee_loader (
    input wire logic clk,
    input wire logic rst,
    input wire logic boardEepromClaim,
    input wire logic eeDataIn,
    output logic eeClock,
    output logic eeChipSelect,
    output logic eeDataOut,
    output logic eeCtrlOeN,
    output logic eeDataOeN,
    output logic wordValid,
    output logic [3:0] wordIndex,
    output logic [15:0] wordData,
    output logic loadDone
);
    // All state of the sequencer
    typedef struct packed {
        isa_pnp_pkg::ee_state_t state;
        logic [4:0] cnt;
        logic phase;
        logic [3:0] addr;
        logic [16:0] shift;
        logic sclk;
        logic cs;
        logic ctrlOeN;
        logic dataOeN;
        logic valid;
        logic [15:0] word;
        logic done;
    } ee_t;

    ee_t q;
    ee_t d;

    // Next state of the sequencer
    always_comb begin
        d = q;
        d.valid = 1'b0;
        case (q.state)
            // Wait for on-board logic to let go of the EEPROM
            isa_pnp_pkg::EE_CLAIM: begin
                if (!boardEepromClaim) begin
                    d.state = isa_pnp_pkg::EE_SETTLE;
                    d.cnt = 5'h00;
                end
            end
            // Take the pins with clock and select low
            isa_pnp_pkg::EE_SETTLE: begin
                d.ctrlOeN = 1'b0;
                d.dataOeN = 1'b0;
                d.cnt = q.cnt + 5'h01;
                if (q.cnt == isa_pnp_pkg::SETTLE_CYCLES - 5'h01) begin
                    d.state = isa_pnp_pkg::EE_CMD;
                    d.cnt = 5'h00;
                    d.shift = {isa_pnp_pkg::READ_OPCODE, 4'h0, q.addr, 6'h00};
                end
            end
            // [R17] Opcode out
            // Select leads the first clock by a cycle; data moves with clock low
            isa_pnp_pkg::EE_CMD: begin
                d.cs = 1'b1;
                d.phase = q.cs && !q.phase;
                d.sclk = q.cs && !q.phase;
                if (q.phase) begin
                    d.shift = {q.shift[15:0], 1'b0};
                    d.cnt = q.cnt + 5'h01;
                    if (q.cnt == isa_pnp_pkg::CMD_BITS - 5'h01) begin
                        d.state = isa_pnp_pkg::EE_READ;
                        d.cnt = 5'h00;
                        d.dataOeN = 1'b1;
                    end
                end
            end
            // [R17] Read sampling
            // Sample on each falling clock, keep the last 16 bits
            isa_pnp_pkg::EE_READ: begin
                d.phase = !q.phase;
                d.sclk = !q.phase;
                if (q.phase) begin
                    d.shift = {q.shift[15:0], eeDataIn};
                    d.cnt = q.cnt + 5'h01;
                    if (q.cnt == isa_pnp_pkg::READ_BITS - 5'h01) begin
                        d.state = isa_pnp_pkg::EE_GAP;
                        d.valid = 1'b1;
                        d.word = {q.shift[14:0], eeDataIn};
                    end
                end
            end
            // [R16] Frame end
            // Drop select between words, stop after the last one
            isa_pnp_pkg::EE_GAP: begin
                d.cs = 1'b0;
                d.sclk = 1'b0;
                d.phase = 1'b0;
                d.cnt = 5'h00;
                if (q.addr == 4'(isa_pnp_pkg::NUM_WORDS - 1)) begin
                    d.state = isa_pnp_pkg::EE_DONE;
                end else begin
                    d.addr = q.addr + 4'h1;
                    d.state = isa_pnp_pkg::EE_CMD;
                    d.dataOeN = 1'b0;
                    d.shift = {isa_pnp_pkg::READ_OPCODE, 4'h0, q.addr + 4'h1, 6'h00};
                end
            end
            // [R21] Release pins
            isa_pnp_pkg::EE_DONE: begin
                d.ctrlOeN = 1'b1;
                d.dataOeN = 1'b1;
                d.done = 1'b1;
            end
            default: begin
                d.state = isa_pnp_pkg::EE_CLAIM;
            end
        endcase
    end

    // State register; reset restarts the whole load
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '{state: isa_pnp_pkg::EE_CLAIM, ctrlOeN: 1'b1, dataOeN: 1'b1, default: '0};
        end else begin
            q <= d;
        end
    end

    assign eeClock = q.sclk;
    assign eeChipSelect = q.cs;
    assign eeDataOut = q.shift[16];
    assign eeCtrlOeN = q.ctrlOeN;
    assign eeDataOeN = q.dataOeN;
    assign wordValid = q.valid;
    assign wordIndex = q.addr;
    assign wordData = q.word;
    assign loadDone = q.done;
endmodule : ee_loader

// ==== src/isa_pnp_card_resource_router.sv ====
`timescale 1ns/1ps
// Behaviour
// [R01] DMA request pins follow loaded channel mapping
// [R02] Clock comes from ISA oscillator, 10-22 MHz
// [R03] Device DMA wants reach configured ISA request
// [R04] Device grant follows its channel's ISA acknowledge
// [R05] Device interrupts reach their selected ISA line
// [R06] Eleven ISA interrupt outputs, IRQ3 to IRQ15
// [R07] Sixteen-bit I/O compare masked by block size
// [R08] Mode 0 decodes 24-bit memory selects
// [R09] Mode 1 memory pins become I/O selects
// [R10] Transceiver enable on reads to chosen devices
// [R11] Busy output high while configuring
// [R12] Board logic watches busy before EEPROM use
// [R13] Reset clears registers, enters wait-for-key; the code enters loading first and wait-for-key once the load ends
// [R14] Reset reloads defaults, card number zero
// [R15] EEPROM clock driven, released when idle
// [R16] EEPROM select frames each access
// [R17] Shared data line: drive command, sample data
// [R18] Board holds claim during its EEPROM access
// [R19] Address enable blocks every I/O select
// [R20] Mode chosen from loaded mode bit
// [R21] After loading, release EEPROM pins, drop busy
// [R22] Board waits two cycles after busy drops
// [R23] I/O select needs active device and strobe

module isa_pnp_card_resource_router (
    input wire logic clk,
    input wire logic rst,
    input wire logic [23:0] isaAddr,
    input wire logic addrEnable,
    input wire logic ioReadN,
    input wire logic ioWriteN,
    input wire logic [2:0] isaDmaAckN,
    input wire logic deviceDmaWant0,
    input wire logic deviceDmaWant1,
    input wire logic deviceIrqIn0,
    input wire logic deviceIrqIn1,
    input wire logic boardEepromClaim,
    input wire logic eepromSerialDataIn,
    output logic isaDmaRequestOut0,
    output logic isaDmaRequestOut1,
    output logic isaDmaRequestOut2,
    output logic deviceDmaGrant0,
    output logic deviceDmaGrant1,
    output logic [10:0] isaIrq,
    output logic ioSelect0,
    output logic ioSelect1,
    output logic memSelect0,
    output logic memSelect1,
    output logic xcvrEnable0,
    output logic configBusyOut,
    output logic [7:0] cardSelectNumber,
    output logic eepromClock,
    output logic eepromClockOeN,
    output logic eepromChipSelect,
    output logic eepromChipSelectOeN,
    output logic eepromSerialDataOut,
    output logic eepromSerialDataOeN
);
    // All registered state of the router
    typedef struct packed {
        logic [isa_pnp_pkg::NUM_WORDS-1:0][15:0] words;
        isa_pnp_pkg::pnp_state_t pnp;
        logic [7:0] card_select_number;
        logic [10:0] irq;
        logic [2:0] dmaReq;
        logic [1:0] grant;
        logic [1:0] ioSel;
        logic [1:0] memSel;
        logic xcvr;
        logic busy;
    } router_t;

    router_t q;
    router_t d;

    // Loader results
    logic wordValid;
    logic [3:0] wordIndex;
    logic [15:0] wordData;
    logic loadDone;
    logic eeCtrlOeN;

    // Decoded default fields
    logic mode;
    logic [3:0] active;
    logic [3:0] ioHit;
    logic [1:0] memHit;
    logic [1:0][3:0] irqLevel;
    logic [1:0][2:0] dmaChan;
    logic [2:0][2:0] dmaMap;
    logic [2:0] oenCode;

    logic [10:0] irqHit;
    logic [2:0] dmaHit;
    logic [1:0] grantHit;
    logic ioStrobe;

    // [R15] Clock and select drive
    // [R16] Select framing
    ee_loader u_ee (
        .clk(clk),
        .rst(rst),
        .boardEepromClaim(boardEepromClaim),
        .eeDataIn(eepromSerialDataIn),
        .eeClock(eepromClock),
        .eeChipSelect(eepromChipSelect),
        .eeDataOut(eepromSerialDataOut),
        .eeCtrlOeN(eeCtrlOeN),
        .eeDataOeN(eepromSerialDataOeN),
        .wordValid(wordValid),
        .wordIndex(wordIndex),
        .wordData(wordData),
        .loadDone(loadDone)
    );

    // Clock and select share one enable; both are pulled down when free
    assign eepromClockOeN = eeCtrlOeN;
    assign eepromChipSelectOeN = eeCtrlOeN;

    // [R20] Mode bit
    assign mode = q.words[isa_pnp_pkg::CTRL_WORD][isa_pnp_pkg::MODE_BIT];
    assign oenCode = q.words[isa_pnp_pkg::CTRL_WORD][isa_pnp_pkg::XCVR_ENABLE_0_LSB +: 3];

    // I/O strobes are active low on the ISA side
    assign ioStrobe = !ioReadN || !ioWriteN;

    // Per-device fields and I/O address compare
    for (genvar n = 0; n < 4; n++) begin : g_dev
        assign active[n] = q.words[isa_pnp_pkg::CTRL_WORD][isa_pnp_pkg::ACTIVE_TOP - n];

        // [R07] Masked compare
        io_match u_match (
            .addr(isaAddr[15:0]),
            .base(q.words[isa_pnp_pkg::IO_BASE_WORD0 + 4'(n)]),
            .sizeCode(q.words[isa_pnp_pkg::SIZE_WORD][isa_pnp_pkg::SIZE_TOP
                - isa_pnp_pkg::SIZE_STEP * n -: 3]),
            .hit(ioHit[n])
        );
    end

    // Fields and memory windows of devices 0 and 1
    for (genvar n = 0; n < 2; n++) begin : g_ld
        assign irqLevel[n] = q.words[isa_pnp_pkg::IRQ_WORD][isa_pnp_pkg::IRQ_TOP
            - isa_pnp_pkg::IRQ_STEP * n -: 4];
        assign dmaChan[n] = q.words[isa_pnp_pkg::DMA_CHAN_WORD][isa_pnp_pkg::DMA_CHAN_TOP
            - isa_pnp_pkg::DMA_CHAN_STEP * n -: 3];

        // [R08] Memory window
        assign memHit[n] = (isaAddr[23:8] >= q.words[isa_pnp_pkg::MEM_BASE_WORD0 + 4'(n)])
            && (isaAddr[23:8] <= q.words[isa_pnp_pkg::MEM_UPPER_WORD0 + 4'(n)]);

        // [R04] Grant from acknowledge
        assign grantHit[n] = (dmaMap[0] == dmaChan[n] && !isaDmaAckN[0])
            || (dmaMap[1] == dmaChan[n] && !isaDmaAckN[1])
            || (dmaMap[2] == dmaChan[n] && !isaDmaAckN[2]);
    end

    // [R01] Channel mapping
    // [R03] Request forwarding
    for (genvar k = 0; k < 3; k++) begin : g_dma
        assign dmaMap[k] = q.words[isa_pnp_pkg::DMA_MAP_WORD][isa_pnp_pkg::DMA_MAP_STEP * k +: 3];

        assign dmaHit[k] = (active[0] && deviceDmaWant0 && dmaChan[0] == dmaMap[k])
            || (active[1] && deviceDmaWant1 && dmaChan[1] == dmaMap[k]);
    end

    // [R05] Interrupt routing
    // [R06] Eleven lines
    for (genvar k = 0; k < 11; k++) begin : g_irq
        // Level of this line
        localparam logic [3:0] LEVEL = isa_pnp_pkg::IRQ_LEVEL_LIST[4*k +: 4];
        assign irqHit[k] = (active[0] && deviceIrqIn0 && irqLevel[0] == LEVEL)
            || (active[1] && deviceIrqIn1 && irqLevel[1] == LEVEL);
    end

    // Next state: defaults capture, load sequence and registered outputs
    always_comb begin
        d = q;

        // Capture each default word as it arrives
        if (wordValid) begin
            d.words[wordIndex] = wordData;
        end

        // [R21] Leave loading when the loader finishes
        if (q.pnp == isa_pnp_pkg::PNP_LOADING && loadDone) begin
            d.pnp = isa_pnp_pkg::PNP_WAIT_KEY;
        end

        // [R11] Busy while loading
        d.busy = (d.pnp == isa_pnp_pkg::PNP_LOADING);
        d.irq = irqHit;
        d.dmaReq = dmaHit;
        d.grant = grantHit;

        // [R19] Address enable blocks
        // [R23] Active and strobed
        d.ioSel = (ioStrobe && !addrEnable) ? (active[1:0] & ioHit[1:0]) : 2'b00;
        if (mode) begin
            // [R09] Pins carry devices 3 and 2
            d.memSel[0] = ioStrobe && !addrEnable && active[3] && ioHit[3];
            d.memSel[1] = ioStrobe && !addrEnable && active[2] && ioHit[2];
        end else begin
            // [R08] Memory selects in mode 0
            d.memSel = active[1:0] & memHit;
        end

        // [R10] Transceiver enable on reads
        d.xcvr = 1'b0;
        if (!ioReadN && !addrEnable) begin
            if (mode) begin
                d.xcvr = (oenCode < 3'h4) ? (active[oenCode[1:0]] && ioHit[oenCode[1:0]])
                    : (oenCode == 3'h4);
            end else begin
                case (oenCode)
                    isa_pnp_pkg::OEN_LD0: d.xcvr = d.ioSel[0];
                    isa_pnp_pkg::OEN_LD1: d.xcvr = d.ioSel[1];
                    isa_pnp_pkg::OEN_EITHER: d.xcvr = |d.ioSel;
                    default: d.xcvr = 1'b0;
                endcase
            end
        end
    end

    // [R13] Reset clears state
    // [R14] Reload and card number zero
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '{words: '{default: isa_pnp_pkg::WORD_RESET},
                pnp: isa_pnp_pkg::PNP_LOADING, card_select_number: isa_pnp_pkg::CSN_RESET,
                busy: 1'b1, default: '0};
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flops
    assign isaDmaRequestOut0 = q.dmaReq[0];
    assign isaDmaRequestOut1 = q.dmaReq[1];
    assign isaDmaRequestOut2 = q.dmaReq[2];

    assign deviceDmaGrant0 = q.grant[0];
    assign deviceDmaGrant1 = q.grant[1];

    assign isaIrq = q.irq;

    assign ioSelect0 = q.ioSel[0];
    assign ioSelect1 = q.ioSel[1];
    assign memSelect0 = q.memSel[0];
    assign memSelect1 = q.memSel[1];

    assign xcvrEnable0 = q.xcvr;
    assign configBusyOut = q.busy;
    assign cardSelectNumber = q.card_select_number;

    // [R19] Check address enable
    a_aen_blocks_io: assert property (@(posedge clk) disable iff (rst) // [R19]
        addrEnable |=> !ioSelect0 && !ioSelect1 && !(mode && (memSelect0 || memSelect1)))
        else $error("I/O select during address enable");

    // [R23] Check strobe needed
    a_io_needs_strobe: assert property (@(posedge clk) disable iff (rst) // [R23]
        ioReadN && ioWriteN |=> !ioSelect0 && !ioSelect1)
        else $error("I/O select without strobe");

    // [R13] Check reset state
    a_reset_busy_csn: assert property (@(posedge clk) // [R13]
        rst |=> configBusyOut && cardSelectNumber == isa_pnp_pkg::CSN_RESET
            && !ioSelect0 && !isaDmaRequestOut0)
        else $error("Reset state wrong");

    // [R21] Check pins released
    a_idle_releases: assert property (@(posedge clk) disable iff (rst) // [R21]
        !configBusyOut |-> eepromClockOeN && eepromChipSelectOeN && eepromSerialDataOeN)
        else $error("EEPROM pins driven after configuration");

    // [R11] Check busy tracks loading
    a_busy_drops_once: assert property (@(posedge clk) disable iff (rst) // [R11]
        $fell(configBusyOut) |-> $past(loadDone) ##1 !configBusyOut [*3])
        else $error("Busy dropped without load or rose again");

    // [R05] Check interrupt route
    a_irq_route: assert property (@(posedge clk) disable iff (rst) // [R05]
        (active[0] && deviceIrqIn0 && irqLevel[0] == 4'h5) |=> isaIrq[2])
        else $error("Interrupt of device 0 not on its line");

    // [R03] Check request route
    a_dma_route: assert property (@(posedge clk) disable iff (rst) // [R03]
        (active[0] && deviceDmaWant0 && dmaChan[0] == dmaMap[1]) |=> isaDmaRequestOut1)
        else $error("DMA request of device 0 not forwarded");

    // [R04] Check grant route
    a_dma_grant: assert property (@(posedge clk) disable iff (rst) // [R04]
        (dmaMap[0] == dmaChan[1] && !isaDmaAckN[0]) |=> deviceDmaGrant1)
        else $error("DMA grant of device 1 missing");

    // [R10] Check enable follows read select
    a_xcvr_on_read: assert property (@(posedge clk) disable iff (rst) // [R10]
        (ioSelect0 && !$past(ioReadN) && !mode && oenCode == isa_pnp_pkg::OEN_EITHER)
            |-> xcvrEnable0)
        else $error("Transceiver enable missing on read");
endmodule : isa_pnp_card_resource_router

// ==== dv/eeprom_model.sv ====
`timescale 1ns/1ps
// Serial EEPROM model holding the card's default image
module eeprom_model (
    input wire logic eeClock,
    input wire logic eeSelect,
    input wire logic eeData,
    output logic dataDrive,
    output logic dataOut,
    output int numReads
);
    // Stored words, filled by the bench
    logic [15:0] mem [0:13];
    // Command shift register and latched read address
    logic [10:0] cmd = 11'h000;
    logic [7:0] readAddr = 8'h00;
    // Rising clocks seen in the current frame
    int bitCount = 0;
    initial begin
        dataDrive = 1'b0;
        dataOut = 1'b0;
        numReads = 0;
    end
    // Command bits are taken on the rising serial clock
    always @(posedge eeClock) begin
        if (eeSelect) begin
            cmd = {cmd[9:0], eeData};
            bitCount = bitCount + 1;
        end
    end
    // Read data changes on the falling clock
    always @(negedge eeClock) begin
        if (eeSelect && bitCount == 11) begin
            readAddr = cmd[7:0];
            dataDrive = 1'b1;
            // Dummy zero ahead of the word
            dataOut = 1'b0;
            // Reads in order from word 0 are counted
            if (cmd[10:8] == isa_pnp_pkg::READ_OPCODE) begin
                numReads = (readAddr == 8'h00) ? 1 : numReads + int'(readAddr == numReads[7:0]);
            end
        end else if (eeSelect && bitCount >= 12 && bitCount <= 27) begin
            dataOut = mem[readAddr][27 - bitCount];
        end else begin
            // Word done: free the line
            dataDrive = 1'b0;
        end
    end
    // Deselect ends the frame and frees the line
    always @(negedge eeSelect) begin
        bitCount = 0;
        dataDrive = 1'b0;
    end
endmodule : eeprom_model

// ==== dv/isa_pnp_card_resource_router_tb.sv ====
`timescale 1ns/1ps
// Self-checking bench for the card resource router
module isa_pnp_card_resource_router_tb;
    // Bench-driven inputs
    logic clk, rst, addrEnable, ioReadN, ioWriteN, boardEepromClaim;
    logic deviceDmaWant0, deviceDmaWant1, deviceIrqIn0, deviceIrqIn1;
    logic [23:0] isaAddr;
    logic [2:0] isaDmaAckN;
    // Design outputs and model drive
    logic isaDmaRequestOut0, isaDmaRequestOut1, isaDmaRequestOut2, deviceDmaGrant0;
    logic deviceDmaGrant1, ioSelect0, ioSelect1, memSelect0, memSelect1, xcvrEnable0;
    logic configBusyOut, eepromClock, eepromClockOeN, eepromChipSelect, eepromChipSelectOeN;
    logic eepromSerialDataOut, eepromSerialDataOeN, modelDrive, modelOut;
    logic [10:0] isaIrq;
    logic [7:0] cardSelectNumber;
    int n_fail = 0, num_checks = 0, cycles = 0, numReads;
    // Bits of the routing vector
    localparam logic [20:0] XC = 21'h000001, M0 = 21'h000002, M1 = 21'h000004;
    localparam logic [20:0] IO0 = 21'h000008, IO1 = 21'h000010, IRQ5 = 21'h000080;
    localparam logic [20:0] IRQ11 = 21'h001000, GR0 = 21'h010000, GR1 = 21'h020000;
    localparam logic [20:0] DQ0 = 21'h040000, DQ1 = 21'h080000;
    // Strobe sets {addrEnable, ioReadN, ioWriteN}
    localparam logic [2:0] IDLE = 3'h3, RD = 3'h1, WR = 3'h2, AEN_RD = 3'h5;
    // Released EEPROM lines fall to their pulldown level
    wire logic eeClk = (eepromClockOeN === 1'b0) ? eepromClock : 1'b0;
    wire logic eeSel = (eepromChipSelectOeN === 1'b0) ? eepromChipSelect : 1'b0;
    wire logic eeData = (eepromSerialDataOeN === 1'b0) ? eepromSerialDataOut :
        (modelDrive ? modelOut : 1'b0);
    // All routed outputs in one vector
    wire logic [20:0] route = {isaDmaRequestOut2, isaDmaRequestOut1, isaDmaRequestOut0,
        deviceDmaGrant1, deviceDmaGrant0, isaIrq, ioSelect1, ioSelect0, memSelect1,
        memSelect0, xcvrEnable0};
    // Busy, three releases, card number
    wire logic [15:0] ctlView = {configBusyOut, eepromClockOeN, eepromChipSelectOeN,
        eepromSerialDataOeN, 4'h0, cardSelectNumber};

    isa_pnp_card_resource_router isa_pnp_card_resource_router_i (
        .clk(clk), .rst(rst), .isaAddr(isaAddr), .addrEnable(addrEnable),
        .ioReadN(ioReadN), .ioWriteN(ioWriteN), .isaDmaAckN(isaDmaAckN),
        .deviceDmaWant0(deviceDmaWant0), .deviceDmaWant1(deviceDmaWant1),
        .deviceIrqIn0(deviceIrqIn0), .deviceIrqIn1(deviceIrqIn1),
        .boardEepromClaim(boardEepromClaim), .eepromSerialDataIn(eeData),
        .isaDmaRequestOut0(isaDmaRequestOut0), .isaDmaRequestOut1(isaDmaRequestOut1),
        .isaDmaRequestOut2(isaDmaRequestOut2), .deviceDmaGrant0(deviceDmaGrant0),
        .deviceDmaGrant1(deviceDmaGrant1), .isaIrq(isaIrq), .ioSelect0(ioSelect0),
        .ioSelect1(ioSelect1), .memSelect0(memSelect0), .memSelect1(memSelect1),
        .xcvrEnable0(xcvrEnable0), .configBusyOut(configBusyOut),
        .cardSelectNumber(cardSelectNumber), .eepromClock(eepromClock),
        .eepromClockOeN(eepromClockOeN), .eepromChipSelect(eepromChipSelect),
        .eepromChipSelectOeN(eepromChipSelectOeN), .eepromSerialDataOut(eepromSerialDataOut),
        .eepromSerialDataOeN(eepromSerialDataOeN)
    );

    eeprom_model eeprom_model_i (
        .eeClock(eeClk), .eeSelect(eeSel), .eeData(eeData),
        .dataDrive(modelDrive), .dataOut(modelOut), .numReads(numReads)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail++;
            report_and_stop();
        end
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    task automatic check_route(input logic [20:0] exp);
        num_checks++;
        if (route !== exp) begin
            n_fail++;
            $display("MISMATCH %0t route %h expected %h", $time, route, exp);
        end
    endtask : check_route

    task automatic check_sig(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t status %h expected %h", $time, got, exp);
        end
    endtask : check_sig

    // Drive inputs, judge outputs one edge later
    task automatic step(input logic [23:0] a, input logic [2:0] ctl, input logic [2:0] ack,
        input logic [3:0] dev, input logic [20:0] exp);
        {addrEnable, ioReadN, ioWriteN} = ctl;
        isaAddr = a;
        isaDmaAckN = ack;
        {deviceDmaWant1, deviceDmaWant0, deviceIrqIn1, deviceIrqIn0} = dev;
        @(posedge clk);
        #1;
        check_route(exp);
    endtask : step

    // Default image; mode 1 turns on devices 2 and 3, transceiver on device 3
    task automatic load_image(input logic mode1);
        eeprom_model_i.mem = '{16'h0d00, 16'h0e00, 16'h0d0f, 16'h0e00, 16'h0300, 16'h0220,
            16'h0280, 16'h0290, 16'h0000, 16'h6000, 16'h5b00, 16'h02c0,
            mode1 ? 16'hf310 : 16'hc200, 16'h014b};
    endtask : load_image

    // Reset; the board may hold the EEPROM after it
    task automatic do_reset(input int claimCycles);
        rst = 1'b1;
        boardEepromClaim = (claimCycles > 0);
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        check_sig(ctlView, 16'hf000);
        check_route(21'h0);
        repeat (claimCycles) begin
            @(posedge clk);
            #1;
        end
        check_sig(ctlView, 16'hf000);
        boardEepromClaim = 1'b0;
    endtask : do_reset

    task automatic wait_load;
        int n;
        n = 0;
        while (configBusyOut !== 1'b0 && n < 1000) begin
            @(posedge clk);
            #1;
            n++;
        end
        check_sig(ctlView, 16'h7000);
        check_sig(numReads[15:0], 16'(isa_pnp_pkg::NUM_WORDS));
    endtask : wait_load

    task automatic t_irq;
        step(24'h0, IDLE, 3'h7, 4'h1, IRQ5);
        step(24'h0, IDLE, 3'h7, 4'h2, IRQ11);
        step(24'h0, IDLE, 3'h7, 4'h3, IRQ5 | IRQ11);
    endtask : t_irq

    task automatic t_dma;
        step(24'h0, IDLE, 3'h7, 4'h4, DQ1);
        step(24'h0, IDLE, 3'h7, 4'h8, DQ0);
        step(24'h0, IDLE, 3'h5, 4'h0, GR0);
        step(24'h0, IDLE, 3'h6, 4'h0, GR1);
        step(24'h0, IDLE, 3'h3, 4'h0, 21'h0);
    endtask : t_dma

    task automatic t_io;
        step(24'h000300, RD, 3'h7, 4'h0, IO0 | XC);
        step(24'h000307, RD, 3'h7, 4'h0, IO0 | XC);
        step(24'h000308, RD, 3'h7, 4'h0, 21'h0);
        step(24'h000220, WR, 3'h7, 4'h0, IO1);
        step(24'h000221, WR, 3'h7, 4'h0, 21'h0);
        step(24'h000220, AEN_RD, 3'h7, 4'h0, 21'h0);
        step(24'h000300, IDLE, 3'h7, 4'h0, 21'h0);
        step(24'h000220, RD, 3'h7, 4'h0, IO1 | XC);
    endtask : t_io

    task automatic t_mem;
        step(24'h0d0000, IDLE, 3'h7, 4'h0, M0);
        step(24'h0d0fff, IDLE, 3'h7, 4'h0, M0);
        step(24'h0d1000, IDLE, 3'h7, 4'h0, 21'h0);
        step(24'h0cffff, IDLE, 3'h7, 4'h0, 21'h0);
        step(24'h0e00ab, IDLE, 3'h7, 4'h0, M1);
    endtask : t_mem

    // Reload in mode 1, with a second reset in mid-load
    task automatic t_mode1;
        load_image(1'b1);
        do_reset(0);
        repeat (300) @(posedge clk);
        #1;
        check_sig(16'(ctlView[15]), 16'h1);
        do_reset(0);
        wait_load();
        step(24'h000280, RD, 3'h7, 4'h0, M1);
        step(24'h000290, RD, 3'h7, 4'h0, M0 | XC);
        step(24'h000300, RD, 3'h7, 4'h0, IO0);
        step(24'h000290, AEN_RD, 3'h7, 4'h0, 21'h0);
        step(24'h0d0000, IDLE, 3'h7, 4'h0, 21'h0);
    endtask : t_mode1

    initial begin
        rst = 1'b1;
        boardEepromClaim = 1'b1;
        isaAddr = 24'h0;
        {addrEnable, ioReadN, ioWriteN} = IDLE;
        isaDmaAckN = 3'h7;
        {deviceDmaWant1, deviceDmaWant0, deviceIrqIn1, deviceIrqIn0} = 4'h0;
        load_image(1'b0);
        do_reset(20);
        wait_load();
        t_irq();
        t_dma();
        t_io();
        t_mem();
        t_mode1();
        report_and_stop();
    end
endmodule : isa_pnp_card_resource_router_tb
